// File: hdl/cc_timer.sv
// Single-channel capture/compare timer with 16-bit upcounter, AXI4-Lite slave.
// Assumes in_pin is asynchronous, debug_halt comes from the core's clock domain.
module cc_timer (
  input  wire logic                  sys_clk,    // Kernel clock, 200 MHz
  input  wire logic                  sys_rst,    // Synchronous reset, active high
  input  wire logic                  clk_en,     // Freezes all state while low
  input  wire cc_timer_pkg::axil_req_s bus_req,  // AXI4-Lite request channels
  output      cc_timer_pkg::axil_rsp_s bus_rsp,  // AXI4-Lite response channels
  input  wire logic                  in_pin,     // channel_input, asynchronous
  input  wire logic                  debug_halt, // Core halted in debug
  output      logic                  out_pin,    // channel_output level
  output      logic                  out_oe_n,   // Low while out_pin is driven
  output      logic                  irq         // Channel interrupt request
);
  import cc_timer_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0]  in_sync;
    logic [3:0]  flt_cnt;
    logic        filtered;
    logic [1:0]  div_cnt;
    logic [1:0]  smp_cnt;
    logic [15:0] psc_cnt;
    logic [15:0] count;
    logic [15:0] psc_pre;
    logic [15:0] psc_sh;
    logic [15:0] period_pre;
    logic [15:0] period_sh;
    logic [15:0] value_pre;
    logic [15:0] value_sh;
    logic        ref_lvl;
    logic [9:0]  control;
    logic        irq_en;
    logic        chan_flag;
    logic        over_flag;
    logic        upd_flag;
    logic [6:0]  mode;
    logic [3:0]  enable;
    logic        freeze_sel;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

  state_s st;
  state_s next_st;

  // Required filter run length per code; 0 means no filter
  function automatic logic [3:0] filter_len(input logic [3:0] code);
    case (code)
      4'h0:    filter_len = 4'h1;
      4'h1:    filter_len = 4'h2;
      4'h2:    filter_len = 4'h4;
      4'h3:    filter_len = 4'h8;
      4'h4:    filter_len = 4'hA;
      4'h5:    filter_len = 4'hC;
      default: filter_len = 4'hF;
    endcase
  endfunction : filter_len

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // ==========================================================================
  // Combinational next state
  logic        input_mode;
  logic        tick;
  logic        wrap;
  logic        update;
  logic        smp_stb;
  logic        edge_q;
  logic        capture;
  logic        match;
  logic        do_wr;
  logic        do_rd;
  logic [31:0] wv;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic        wr_ok;
  logic        pwm1;
  logic [2:0]  act;
  logic [1:0]  scd;

  always_comb begin
    next_st    = st;
    input_mode = st.mode[DIR_LSB +: 2] != DIR_OUTPUT;
    act        = st.mode[ACT_LSB +: 3];
    scd        = st.control[SCD_LSB +: 2];
    do_wr      = st.aw_held && st.w_held && !st.bvalid;
    do_rd      = bus_req.arvalid && !st.rvalid;
    wv         = merge(32'h0, st.w_data, st.w_strb);
    wr_ok      = 1'b1;
    rd_ok      = 1'b1;
    rd_word    = 32'h0;

    // Input synchroniser; only the second stage is read
    next_st.in_sync = {st.in_sync[0], in_pin};

    // Sample strobe at 1, 2 or 4 kernel periods; 11 treated as 4
    smp_stb = 1'b0;
    next_st.smp_cnt = st.smp_cnt + 2'h1;
    if (scd == 2'h0) begin
      smp_stb = 1'b1;
    end else if (scd == 2'h1) begin
      smp_stb = st.smp_cnt[0];
    end else begin
      smp_stb = &st.smp_cnt;
    end

    // Filter: new level accepted after run of equal samples
    if (smp_stb) begin
      if (st.in_sync[1] == st.filtered) begin
        next_st.flt_cnt = 4'h0;
      end else if (st.flt_cnt + 4'h1 >= filter_len({1'b0, st.mode[FLT_LSB +: 3]})) begin
        next_st.filtered = st.in_sync[1];
        next_st.flt_cnt  = 4'h0;
      end else begin
        next_st.flt_cnt = st.flt_cnt + 4'h1;
      end
    end

    // Edge select: 00 rising, 01 falling, 11 both
    edge_q = 1'b0;
    if (next_st.filtered != st.filtered) begin
      if (st.enable[POL_BIT] && st.enable[POLX_BIT]) begin
        edge_q = 1'b1;
      end else if (st.enable[POL_BIT]) begin
        edge_q = !next_st.filtered;
      end else begin
        edge_q = next_st.filtered;
      end
    end

    // Capture divider by 1, 2 or 4 edges; 11 treated as 4
    capture = 1'b0;
    if (input_mode && st.enable[CHEN_BIT] && edge_q) begin
      next_st.div_cnt = st.div_cnt + 2'h1;
      case (st.mode[DIV_LSB +: 2])
        2'h0:    capture = 1'b1;
        2'h1:    capture = st.div_cnt[0];
        2'h2:    capture = &st.div_cnt;
        default: capture = &st.div_cnt;
      endcase
    end

    // Time base: prescaler then counter, halted by run bit or debug freeze
    tick = st.control[RUN_BIT] && !(debug_halt && st.freeze_sel);
    wrap = 1'b0;
    if (tick) begin
      if (st.psc_cnt >= st.psc_sh) begin
        next_st.psc_cnt = 16'h0;
        wrap = st.count >= st.period_sh;
        next_st.count = wrap ? 16'h0 : st.count + 16'h1;
      end else begin
        next_st.psc_cnt = st.psc_cnt + 16'h1;
      end
    end
    update = wrap || (do_wr && st.aw_addr == EVENT_OFS && wv[UPD_BIT]);
    if (update) begin
      next_st.psc_sh  = st.psc_pre;
      next_st.upd_flag = 1'b1;
      if (!wrap) begin
        next_st.count   = 16'h0;
        next_st.psc_cnt = 16'h0;
      end
      if (st.control[PPRE_BIT]) begin
        next_st.period_sh = st.period_pre;
      end
      if (!input_mode && st.mode[CPE_BIT]) begin
        next_st.value_sh = st.value_pre;
      end
    end
    if (!st.control[PPRE_BIT]) begin
      next_st.period_sh = st.period_pre;
    end
    if (!input_mode && !st.mode[CPE_BIT]) begin
      next_st.value_sh = st.value_pre;
    end

    // Compare match once per count step
    match = !input_mode && tick && st.psc_cnt >= st.psc_sh
            && st.count == st.value_sh;
    pwm1 = st.count < st.value_sh;
    case (act)
      ACT_SET:      if (match) next_st.ref_lvl = 1'b1;
      ACT_CLEAR:    if (match) next_st.ref_lvl = 1'b0;
      ACT_TOGGLE:   if (match) next_st.ref_lvl = !st.ref_lvl;
      ACT_FORCE_LO: next_st.ref_lvl = 1'b0;
      ACT_FORCE_HI: next_st.ref_lvl = 1'b1;
      ACT_PWM1:     next_st.ref_lvl = pwm1;
      ACT_PWM2:     next_st.ref_lvl = !pwm1;
      default:      next_st.ref_lvl = st.ref_lvl;
    endcase

    // Register reads
    if (do_rd) begin
      if (bus_req.araddr == CONTROL_OFS) begin
        rd_word[9:0] = st.control;
      end else if (bus_req.araddr == IRQ_EN_OFS) begin
        rd_word[CHIE_BIT] = st.irq_en;
      end else if (bus_req.araddr == STATUS_OFS) begin
        rd_word[UPD_BIT] = st.upd_flag;
        rd_word[CHF_BIT] = st.chan_flag;
        rd_word[OVC_BIT] = st.over_flag;
      end else if (bus_req.araddr == EVENT_OFS) begin
        rd_word = 32'h0;
      end else if (bus_req.araddr == MODE_OFS) begin
        rd_word[6:0] = st.mode;
      end else if (bus_req.araddr == ENABLE_OFS) begin
        rd_word[3:0] = st.enable;
      end else if (bus_req.araddr == COUNT_OFS) begin
        rd_word[15:0] = st.count;
      end else if (bus_req.araddr == PERIOD_OFS) begin
        rd_word[15:0] = st.period_pre;
      end else if (bus_req.araddr == CHANNEL_OFS) begin
        rd_word[15:0] = st.value_pre;
        if (input_mode) begin
          next_st.chan_flag = 1'b0;
        end
      end else if (bus_req.araddr == FREEZE_OFS) begin
        rd_word[0] = st.freeze_sel;
      end else begin
        rd_ok = 1'b0;
      end
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_ok ? AXI_OKAY : AXI_SLVERR;
    end
    if (st.rvalid && bus_req.rready) begin
      next_st.rvalid = 1'b0;
    end

    // Register writes, byte strobes honoured; irq enable and freeze bits take an unstrobed lane 0 as zero
    if (do_wr) begin
      if (st.aw_addr == CONTROL_OFS) begin
        next_st.control = 10'(merge({22'h0, st.control}, st.w_data, st.w_strb));
      end else if (st.aw_addr == IRQ_EN_OFS) begin
        next_st.irq_en = wv[CHIE_BIT];
      end else if (st.aw_addr == STATUS_OFS) begin
        if (st.w_strb[0] && !wv[UPD_BIT] && !wrap) next_st.upd_flag = 1'b0;
        if (st.w_strb[0] && !wv[CHF_BIT]) next_st.chan_flag = 1'b0;
        if (st.w_strb[1] && !wv[OVC_BIT]) next_st.over_flag = 1'b0;
      end else if (st.aw_addr == EVENT_OFS) begin
        wr_ok = 1'b1;
      end else if (st.aw_addr == MODE_OFS) begin
        next_st.mode = 7'(merge({25'h0, st.mode}, st.w_data, st.w_strb));
      end else if (st.aw_addr == ENABLE_OFS) begin
        next_st.enable = 4'(merge({28'h0, st.enable}, st.w_data, st.w_strb));
      end else if (st.aw_addr == COUNT_OFS) begin
        next_st.count = 16'(merge({16'h0, st.count}, st.w_data, st.w_strb));
      end else if (st.aw_addr == PERIOD_OFS) begin
        next_st.period_pre = 16'(merge({16'h0, st.period_pre}, st.w_data, st.w_strb));
      end else if (st.aw_addr == CHANNEL_OFS) begin
        if (!input_mode) begin
          next_st.value_pre = 16'(merge({16'h0, st.value_pre}, st.w_data, st.w_strb));
        end
      end else if (st.aw_addr == FREEZE_OFS) begin
        next_st.freeze_sel = wv[0];
      end else begin
        wr_ok = 1'b0;
      end
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_ok ? AXI_OKAY : AXI_SLVERR;
    end
    if (st.bvalid && bus_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    // Capture / software event / match set the channel flag; set beats clear
    if (capture || (do_wr && st.aw_addr == EVENT_OFS && wv[CHF_BIT] && input_mode)) begin
      next_st.value_sh  = st.count;
      next_st.value_pre = st.count;
      next_st.chan_flag = 1'b1;
      if (st.chan_flag) begin
        next_st.over_flag = 1'b1;
      end
    end
    if (match || (do_wr && st.aw_addr == EVENT_OFS && wv[CHF_BIT] && !input_mode)) begin
      next_st.chan_flag = 1'b1;
    end

    // Address and data accepted independently
    if (bus_req.awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = bus_req.awaddr;
    end
    if (bus_req.wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = bus_req.wdata;
      next_st.w_strb = bus_req.wstrb;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st           <= '0;
      st.psc_pre   <= 16'h0;
      st.period_pre <= PERIOD_RST;
      st.period_sh <= PERIOD_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    bus_rsp         = '0;
    bus_rsp.awready = !st.aw_held;
    bus_rsp.wready  = !st.w_held;
    bus_rsp.bvalid  = st.bvalid;
    bus_rsp.bresp   = st.bresp;
    bus_rsp.arready = !st.rvalid;
    bus_rsp.rvalid  = st.rvalid;
    bus_rsp.rdata   = st.rdata;
    bus_rsp.rresp   = st.rresp;
  end
  assign out_pin  = st.ref_lvl ^ st.enable[POL_BIT];
  assign out_oe_n = !(st.enable[CHEN_BIT] && !input_mode);
  assign irq      = st.chan_flag && st.irq_en;

  // ==========================================================================
  // Checks
  overcap_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && capture && st.chan_flag |=> st.over_flag)
    else $error("overcapture not flagged");
  capture_val_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && capture |=> st.value_pre == $past(st.count) && st.chan_flag)
    else $error("capture value wrong");
  force_hi_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && act == ACT_FORCE_HI |=> st.ref_lvl)
    else $error("force high failed");
  pol_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    out_pin == (st.ref_lvl ^ st.enable[POL_BIT]))
    else $error("output polarity wrong");
  oe_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st.enable[CHEN_BIT] |-> out_oe_n)
    else $error("pin driven while disabled");
  wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && wrap |=> st.count == 16'h0 && st.upd_flag)
    else $error("counter did not wrap");
  no_cap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st.enable[CHEN_BIT] |-> !capture)
    else $error("capture while disabled");
  pwm1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && act == ACT_PWM1 && st.value_sh == 16'h0 |=> !st.ref_lvl)
    else $error("pwm zero duty not low");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq |-> st.irq_en && st.chan_flag)
    else $error("irq without enable");
  halt_freeze_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && debug_halt && st.freeze_sel && !do_wr |=> st.count == $past(st.count))
    else $error("count moved in debug halt");

endmodule : cc_timer

// File: hdl/cc_timer_pkg.sv
// Constants, register map and carrier types for the capture/compare timer.
// Assumes a 32-bit AXI4-Lite register bus and a single kernel clock.
package cc_timer_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CONTROL_OFS  = 8'h00;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] EVENT_OFS    = 8'h14;
  localparam logic [7:0] MODE_OFS     = 8'h18;
  localparam logic [7:0] ENABLE_OFS   = 8'h20;
  localparam logic [7:0] COUNT_OFS    = 8'h24;
  localparam logic [7:0] PERIOD_OFS   = 8'h2C;
  localparam logic [7:0] CHANNEL_OFS  = 8'h34;
  localparam logic [7:0] FREEZE_OFS   = 8'h38;

  // ==========================================================================
  // Field positions
  localparam int RUN_BIT    = 0;   // control: counter_run_enable
  localparam int PPRE_BIT   = 7;   // control: period_preload_enable
  localparam int SCD_LSB    = 8;   // control: sample_clock_divide[1:0]
  localparam int CHIE_BIT   = 1;   // irq enable: channel_interrupt_enable
  localparam int UPD_BIT    = 0;   // status / event: update
  localparam int CHF_BIT    = 1;   // status / event: channel flag / sw event
  localparam int OVC_BIT    = 9;   // status: overcapture_flag
  localparam int DIR_LSB    = 0;   // mode: channel_direction_select[1:0]
  localparam int CPE_BIT    = 3;   // mode: compare_preload_enable
  localparam int ACT_LSB    = 4;   // mode: compare_action_code[2:0]
  localparam int DIV_LSB    = 2;   // mode (input): capture_divider_code[1:0]
  localparam int FLT_LSB    = 4;   // mode (input): input_filter_code[2:0]
  localparam int CHEN_BIT   = 0;   // enable: channel_enable_bit
  localparam int POL_BIT    = 1;   // enable: output / edge polarity
  localparam int POLX_BIT   = 3;   // enable: edge_polarity_aux_bit

  // ==========================================================================
  // Encodings and reset values
  localparam logic [1:0]  DIR_OUTPUT   = 2'h0;
  localparam logic [2:0]  ACT_FROZEN   = 3'h0;
  localparam logic [2:0]  ACT_SET      = 3'h1;
  localparam logic [2:0]  ACT_CLEAR    = 3'h2;
  localparam logic [2:0]  ACT_TOGGLE   = 3'h3;
  localparam logic [2:0]  ACT_FORCE_LO = 3'h4;
  localparam logic [2:0]  ACT_FORCE_HI = 3'h5;
  localparam logic [2:0]  ACT_PWM1     = 3'h6;
  localparam logic [2:0]  ACT_PWM2     = 3'h7;
  localparam logic [15:0] PERIOD_RST   = 16'hFFFF;
  localparam logic [1:0]  AXI_OKAY     = 2'h0;
  localparam logic [1:0]  AXI_SLVERR   = 2'h2;

  // AXI4-Lite channels grouped by direction
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_s;

endpackage : cc_timer_pkg

// File: dv/cc_pin_model.sv
// Far-side model: drives the channel input and resolves the output pin.
// Assumes the pin carries a pull-up while the block releases it.
module cc_pin_model (
  input  wire logic sys_clk,   // Kernel clock
  input  wire logic out_pin,   // Level the block drives
  input  wire logic out_oe_n,  // Low while the block drives the pin
  output      logic in_pin,    // Channel input toward the block
  output      logic pin_level  // Resolved level on the wire
);
  timeunit 1ns;
  timeprecision 100ps;
  initial in_pin = 1'b0;
  // A released pin shows the pull-up, never the last driven value
  assign pin_level = out_oe_n ? 1'b1 : out_pin;
  // High pulse of n cycles, then a long quiet low so the filter settles
  task automatic pulse(input int n);
    in_pin <= 1'b1;
    repeat (n) @(posedge sys_clk);
    in_pin <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask : pulse
endmodule : cc_pin_model

// File: dv/cc_timer_tb.sv
// Self-checking bench for the capture/compare timer over AXI4-Lite.
// Assumes one bus transfer at a time; expected answers wait in a queue.
module cc_timer_tb;
  import cc_timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] msk;
    logic [1:0]  rsp;
  } exp_s;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  axil_req_s   req = '0;
  axil_rsp_s   rsp;
  logic        in_pin, out_pin, out_oe_n, irq, pin_level;
  logic        clk_en = 1'b1;
  logic        debug_halt = 1'b0;
  exp_s        q[$];
  exp_s        e;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          hi, x, r;
  always #2.5 sys_clk = ~sys_clk;
  cc_timer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_req(req),
    .bus_rsp(rsp), .in_pin(in_pin), .debug_halt(debug_halt), .out_pin(out_pin),
    .out_oe_n(out_oe_n), .irq(irq));
  cc_pin_model pm (.sys_clk(sys_clk), .out_pin(out_pin), .out_oe_n(out_oe_n),
    .in_pin(in_pin), .pin_level(pin_level));
  // ==========================================================================
  // Checking
  task automatic cmp(input logic [31:0] exp_v, input logic [31:0] got);
    n_checks++;
    if (got !== exp_v) begin
      miscompares++;
      $display("CHECK FAILED value expected %h seen %h", exp_v, got);
    end
  endtask : cmp
  // Monitor pops the oldest note at each bus answer
  always @(posedge sys_clk) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
      e = q.pop_front();
      cmp({30'h0, e.rsp}, {30'h0, rsp.bvalid ? rsp.bresp : rsp.rresp});
      if (rsp.rvalid) cmp(e.val & e.msk, rsp.rdata & e.msk);
    end
  end
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // Timeout guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================================================
  // Bus master; each task starts and ends just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs = AXI_OKAY);
    q.push_back('{32'h0, 32'h0, rs});
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    // One idle edge so a following call never re-drives a signal in this step
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                    input logic [1:0] rs = AXI_OKAY);
    q.push_back('{v, m, rs});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h34e4cac0));
    wt(5);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values, self-clearing event bit, unmapped address
    cmp(32'h1, {31'h0, out_oe_n});
    rd(PERIOD_OFS, {16'h0, PERIOD_RST}, 32'hFFFF);
    wr(EVENT_OFS, 32'h1);
    rd(EVENT_OFS, 32'h0, 32'h3);
    rd(8'hF0, 32'h0, 32'h0, AXI_SLVERR);
    $display("test reset done");
    // Forced levels through both polarities
    for (int i = 0; i < 4; i++) begin
      wr(MODE_OFS, {25'h0, (i[0] ? ACT_FORCE_HI : ACT_FORCE_LO), 4'h0});
      wr(ENABLE_OFS, {30'h0, i[1], 1'b1});
      wt(3);
      cmp({31'h0, i[0] ^ i[1]}, {31'h0, pin_level});
    end
    $display("test forced done");
    // Compare match in direct mode: flag, interrupt, clear by write zero
    wr(ENABLE_OFS, 32'h1);
    wr(PERIOD_OFS, 32'd20);
    wr(MODE_OFS, {25'h0, ACT_FORCE_LO, 4'h0});
    wr(MODE_OFS, {25'h0, ACT_SET, 4'h0});
    wr(CHANNEL_OFS, 32'd5);
    wr(IRQ_EN_OFS, 32'h2);
    wr(STATUS_OFS, 32'h0);
    wr(CONTROL_OFS, 32'h1);
    wt(30);
    wr(CONTROL_OFS, 32'h0);
    rd(STATUS_OFS, 32'h3, 32'h3);
    cmp(32'h1, {31'h0, irq});
    cmp(32'h1, {31'h0, pin_level});
    wr(STATUS_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0, 32'h2);
    cmp(32'h0, {31'h0, irq});
    $display("test compare done");
    // Edge-aligned PWM over a period of ten counts
    wr(PERIOD_OFS, 32'd9);
    r = 1 + ($urandom % 8);
    for (int i = 0; i < 4; i++) begin
      x = (i == 2) ? 0 : (i == 3) ? 10 : r;
      wr(MODE_OFS, {25'h0, (i == 1 ? ACT_PWM2 : ACT_PWM1), 4'h8});
      wr(CHANNEL_OFS, x);
      wr(EVENT_OFS, 32'h1);
      wr(CONTROL_OFS, 32'h1);
      wt(5);
      hi = 0;
      repeat (10) begin
        @(posedge sys_clk);
        hi += pin_level;
      end
      cmp((i == 1) ? 10 - x : x, hi);
      wr(CONTROL_OFS, 32'h0);
    end
    $display("test pwm done");
    // Capture: disabled channel, glitch, edge, overcapture, clears
    wr(ENABLE_OFS, 32'h0);
    wr(MODE_OFS, 32'h31);
    wr(STATUS_OFS, 32'h0);
    wr(CONTROL_OFS, 32'h1);
    pm.pulse(30);
    rd(STATUS_OFS, 32'h0, 32'h2);
    wr(ENABLE_OFS, 32'h1);
    pm.pulse(3);
    rd(STATUS_OFS, 32'h0, 32'h2);
    pm.pulse(30);
    rd(STATUS_OFS, 32'h2, 32'h202);
    cmp(32'h1, {31'h0, irq});
    pm.pulse(30);
    rd(STATUS_OFS, 32'h202, 32'h202);
    rd(CHANNEL_OFS, 32'h0, 32'h0);
    rd(STATUS_OFS, 32'h200, 32'h202);
    wr(STATUS_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0, 32'h202);
    wr(EVENT_OFS, 32'h2);
    rd(STATUS_OFS, 32'h2, 32'h2);
    $display("test capture done");
    // Debug halt and clock enable both hold the counter still
    wr(CONTROL_OFS, 32'h0);
    wr(FREEZE_OFS, 32'h1);
    debug_halt <= 1'b1;
    wr(EVENT_OFS, 32'h1);
    wr(STATUS_OFS, 32'h0);
    wr(CONTROL_OFS, 32'h1);
    wt(20);
    rd(STATUS_OFS, 32'h0, 32'h1);
    clk_en <= 1'b0;
    debug_halt <= 1'b0;
    wt(13);
    clk_en <= 1'b1;
    debug_halt <= 1'b1;
    rd(COUNT_OFS, 32'h0, 32'hFFFF);
    debug_halt <= 1'b0;
    wt(20);
    rd(STATUS_OFS, 32'h1, 32'h1);
    $display("test freeze done");
    wt(4);
    finish_test();
  end
endmodule : cc_timer_tb
